// ---- spindle_seq_pkg.sv ----
// constants and state layout for the spindle power sequencer
package spindle_seq_pkg;
    // clock and printed durations
    localparam int CLK_MHZ        = 20;
    localparam int WINDOW_US      = 160;
    localparam int AT_RATE_US     = 20_000;
    localparam int HEADS_LOADED_DELAY_US  = 3_500;
    // cycle counts (exact multiples of the 50 ns period)
    localparam int WINDOW_CYC     = WINDOW_US * CLK_MHZ;
    localparam int AT_RATE_CYC    = AT_RATE_US * CLK_MHZ;
    localparam int HEADS_LOADED_DELAY_CYC = HEADS_LOADED_DELAY_US * CLK_MHZ;
    // counter widths
    localparam int TMR_W          = 20;
    localparam int WIN_W          = 12;
    // sequence counter values
    localparam logic [3:0] SEQ_INIT    = 4'h8;
    localparam logic [3:0] SEQ_EMPTY   = 4'h0;
    localparam logic [3:0] SEQ_FULL    = 4'hF;
    localparam logic [3:0] SEQ_PACK_CK = 4'h2;
    localparam logic [3:0] SEQ_SPD_CK  = 4'h3;
    // positions of the synchronised pins
    localparam int PIN_INIT    = 0;
    localparam int PIN_SEQ     = 1;
    localparam int PIN_START   = 2;
    localparam int PIN_HDEXT   = 3;
    localparam int PIN_EMERGENCY_RETRACT   = 4;
    localparam int PIN_NOTCH   = 5;
    localparam int PIN_SLOW    = 6;
    localparam int PIN_HEADS_LOADED    = 7;
    localparam int PIN_SKINC   = 8;
    localparam int PIN_N       = 9;

    typedef struct packed {
        logic [PIN_N-1:0] sync1;
        logic [PIN_N-1:0] sync2;
        logic [PIN_N-1:0] prev;
        logic [3:0]       count;
        logic             drive_motor;
        logic             retract_ok;
        logic             safety;
        logic             no_pack;
        logic             pack_on;
        logic             brake;
        logic [WIN_W-1:0] window;
        logic [TMR_W-1:0] at_rate_tmr;
        logic [TMR_W-1:0] delay_tmr;
        logic             ready;
    } seq_state_s;
endpackage

// ---- spindle_power_sequencer.sv ----
// spindle power sequencer: counter, motor, brake, retract, speed and ready logic
//
// What this block does
// - lost sequence request drops head load enable
// - heads home and no request: motor off
// - up count stops and holds at fifteen
// - motor off reverses counter, steps down immediately at full count
// - not terminal, motor off: brake energised
// - lost speed resets retract flop via gate
// - emergency retract resets retract flop directly
// - extended heads plus indirect reset sets safety
// - safety latch holds retract until heads home
// - each notch pulse starts 160 us window
// - long notch pulses never fire speed one-shot
// - short notch pulse fires long one-shot
// - long one-shot retriggers, spans one revolution
// - ready flashes with slow tick while sequencing
// - terminal flag hands ready to heads-loaded gate
// - heads loaded releases delay counter load
// - ready steady while loaded, no seek incomplete
// - power-down flashes again, ends dark at zero
// - init loads eight, counts down at tick
// - zero freezes counter; request starts motor, counts up
// - terminal at full sets retract flop next clock
`timescale 1ns/1ps
`default_nettype none
module spindle_power_sequencer #(
    parameter logic [19:0] AT_RATE_CYCLES    = 20'(spindle_seq_pkg::AT_RATE_CYC),
    parameter logic [19:0] HEADS_LOADED_DELAY_CYCLES = 20'(spindle_seq_pkg::HEADS_LOADED_DELAY_CYC)
) (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic arst_n_in,
    // sequencing inputs (asynchronous pins)
    input  wire logic power_init_pulse_in,
    input  wire logic sequence_start_in,
    input  wire logic panel_start_latch_in,
    input  wire logic emergency_retract_in,
    input  wire logic slow_sequence_tick_in,
    // mechanics and servo status (asynchronous pins)
    input  wire logic heads_extended_latch_in,
    input  wire logic notch_sensor_in,
    input  wire logic heads_loaded_in,
    input  wire logic seek_incomplete_in,
    // actuators
    output logic      motor_power_relay_out,
    output logic      brake_out,
    output logic      head_load_enable_n_out,
    // status
    output logic      drive_motor_on_out,
    output logic      counter_terminal_flag_out,
    output logic      at_rate_out,
    output logic      heads_loaded_delayed_out,
    output logic      ready_indicator_out
);
    localparam logic [11:0] WINDOW_CYCLES = 12'(spindle_seq_pkg::WINDOW_CYC);

    spindle_seq_pkg::seq_state_s s_q;
    spindle_seq_pkg::seq_state_s s_d;

    logic [spindle_seq_pkg::PIN_N-1:0] pins;
    logic init, seq_req, hd_ext, emergency_retract, notch, slow, heads_loaded, skinc;
    logic tick, notch_rise, notch_fall, term, at_full, at_zero, at_rate;
    logic qualify, speed_loss, motor_set, motor_clr, retract_set, step;

    assign pins = {seek_incomplete_in, heads_loaded_in, slow_sequence_tick_in, notch_sensor_in,
                   emergency_retract_in, heads_extended_latch_in, panel_start_latch_in,
                   sequence_start_in, power_init_pulse_in};

    always_comb begin
        init       = s_q.sync2[spindle_seq_pkg::PIN_INIT];
        seq_req    = s_q.sync2[spindle_seq_pkg::PIN_SEQ] | s_q.sync2[spindle_seq_pkg::PIN_START];
        hd_ext     = s_q.sync2[spindle_seq_pkg::PIN_HDEXT];
        emergency_retract      = s_q.sync2[spindle_seq_pkg::PIN_EMERGENCY_RETRACT];
        notch      = s_q.sync2[spindle_seq_pkg::PIN_NOTCH];
        slow       = s_q.sync2[spindle_seq_pkg::PIN_SLOW];
        heads_loaded       = s_q.sync2[spindle_seq_pkg::PIN_HEADS_LOADED];
        skinc      = s_q.sync2[spindle_seq_pkg::PIN_SKINC];
        tick       = slow & ~s_q.prev[spindle_seq_pkg::PIN_SLOW];
        notch_rise = notch & ~s_q.prev[spindle_seq_pkg::PIN_NOTCH];
        notch_fall = ~notch & s_q.prev[spindle_seq_pkg::PIN_NOTCH];
        at_full    = s_q.count == spindle_seq_pkg::SEQ_FULL;
        at_zero    = s_q.count == spindle_seq_pkg::SEQ_EMPTY;
        term       = at_full | at_zero;
        at_rate    = s_q.at_rate_tmr != '0;
        // pulse ended inside the window: the nand gate's low-going pulse
        qualify    = notch_fall & (s_q.window != '0);
        speed_loss = ~at_rate & s_q.retract_ok;
        motor_set  = at_zero & ~s_q.brake & seq_req & ~s_q.no_pack;
        motor_clr  = (~seq_req & ~hd_ext) | s_q.no_pack;
        retract_set = at_full & s_q.drive_motor & at_rate & seq_req;
        step       = tick & ~term;
    end

    always_comb begin
        s_d       = s_q;
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;

        // drive motor flip-flop and counter direction
        if (motor_clr && s_q.drive_motor) begin
            s_d.drive_motor = 1'b0;
            if (at_full) begin
                s_d.count = s_q.count - 4'h1;
            end
        end else if (motor_set && !s_q.drive_motor) begin
            s_d.drive_motor = 1'b1;
            s_d.count       = s_q.count + 4'h1;
        end else if (step) begin
            s_d.count = s_q.drive_motor ? s_q.count + 4'h1 : s_q.count - 4'h1;
        end

        // pack-on check at the tick leaving count two, speed check on every clock at count three
        if (tick && s_q.drive_motor && s_q.count == spindle_seq_pkg::SEQ_PACK_CK && !at_rate) begin
            s_d.pack_on = 1'b1;
        end
        if (s_q.drive_motor && s_q.count == spindle_seq_pkg::SEQ_SPD_CK && at_rate && !s_q.pack_on) begin
            s_d.no_pack = 1'b1;
        end
        if (at_zero && !s_q.drive_motor) begin
            s_d.no_pack = 1'b0;
            s_d.pack_on = 1'b0;
        end

        // brake: idle non-terminal count, or a no-pack start
        s_d.brake = (~term & ~s_q.drive_motor) | s_q.no_pack;

        // retract-heads flip-flop; any reset beats the set
        if (retract_set && !s_q.retract_ok) begin
            s_d.retract_ok = 1'b1;
        end
        if (speed_loss && hd_ext) begin
            s_d.safety = 1'b1;
        end else if (!hd_ext) begin
            s_d.safety = 1'b0;
        end
        if (!seq_req || speed_loss || emergency_retract || s_q.safety) begin
            s_d.retract_ok = 1'b0;
        end

        // speed detector one-shots
        if (notch_rise) begin
            s_d.window = WINDOW_CYCLES;
        end else if (s_q.window != '0) begin
            s_d.window = s_q.window - 12'h001;
        end
        if (qualify) begin
            s_d.at_rate_tmr = AT_RATE_CYCLES;
        end else if (at_rate) begin
            s_d.at_rate_tmr = s_q.at_rate_tmr - 20'h0_0001;
        end

        // heads-loaded delay counter, held loaded while heads are not loaded
        if (!heads_loaded) begin
            s_d.delay_tmr = HEADS_LOADED_DELAY_CYCLES;
        end else if (s_q.delay_tmr != '0) begin
            s_d.delay_tmr = s_q.delay_tmr - 20'h0_0001;
        end

        // ready indicator: flashing while sequencing, steady once loaded
        if (!term) begin
            s_d.ready = slow;
        end else if (at_full) begin
            s_d.ready = heads_loaded & (s_q.delay_tmr == '0) & ~skinc;
        end else begin
            s_d.ready = 1'b0;
        end

        // power init loads count eight and the heads-loaded delay, clears all else but the synchronisers and the prev edge register
        if (init) begin
            s_d.count       = spindle_seq_pkg::SEQ_INIT;
            s_d.drive_motor = 1'b0;
            s_d.retract_ok  = 1'b0;
            s_d.safety      = 1'b0;
            s_d.no_pack     = 1'b0;
            s_d.pack_on     = 1'b0;
            s_d.brake       = 1'b0;
            s_d.window      = '0;
            s_d.at_rate_tmr = '0;
            s_d.delay_tmr   = HEADS_LOADED_DELAY_CYCLES;
            s_d.ready       = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q           <= '0;
            s_q.count     <= spindle_seq_pkg::SEQ_INIT;
            s_q.delay_tmr <= HEADS_LOADED_DELAY_CYCLES;
        end else begin
            s_q <= s_d;
        end
    end

    assign motor_power_relay_out     = s_q.drive_motor;
    assign drive_motor_on_out        = s_q.drive_motor;
    assign brake_out                 = s_q.brake;
    // high lets the servo load; falling starts a retract
    assign head_load_enable_n_out    = s_q.retract_ok;
    assign counter_terminal_flag_out = (s_q.count == spindle_seq_pkg::SEQ_FULL) |
                                       (s_q.count == spindle_seq_pkg::SEQ_EMPTY);
    assign at_rate_out               = s_q.at_rate_tmr != '0;
    assign heads_loaded_delayed_out  = s_q.sync2[spindle_seq_pkg::PIN_HEADS_LOADED] & (s_q.delay_tmr == '0);
    assign ready_indicator_out       = s_q.ready;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_qualify;
        qualify && !init;
    endsequence

    sequence s_loaded;
        heads_loaded && s_q.delay_tmr != '0 && !init;
    endsequence

    sequence s_pack_missing;
        s_q.drive_motor && s_q.count == spindle_seq_pkg::SEQ_SPD_CK && at_rate && !s_q.pack_on && !init;
    endsequence

    sequence s_motor_dropped;
        s_q.no_pack ##1 (!s_q.drive_motor && s_q.brake);
    endsequence

    a_counter_holds_full: assert property (
        at_full && s_q.drive_motor && !motor_clr && !init |=> at_full)
        else $error("sequence counter left full count");
    a_down_step_now: assert property (
        at_full && s_q.drive_motor && motor_clr && !init |=> s_q.count == 4'hE && !s_q.drive_motor)
        else $error("down count did not start at once");
    a_brake_idle: assert property (
        !term && !s_q.drive_motor && !init |=> s_q.brake)
        else $error("brake not energised while idle");
    a_seq_loss_retract: assert property (
        !seq_req |=> !s_q.retract_ok)
        else $error("head load enable kept after request lost");
    a_emergency_retract_direct: assert property (
        emergency_retract |=> !s_q.retract_ok)
        else $error("emergency retract ignored");
    a_motor_release: assert property (
        !seq_req && !hd_ext && s_q.drive_motor |=> !s_q.drive_motor)
        else $error("motor relay held with heads home");
    a_safety_hold: assert property (
        s_q.safety && hd_ext |=> !s_q.retract_ok [*2])
        else $error("safety latch failed to hold retract");
    a_speed_fires: assert property (
        s_qualify |=> at_rate_out [*8])
        else $error("qualifying pulse did not raise at rate");
    a_window_len: assert property (
        notch_rise && !init |=> s_q.window == WINDOW_CYCLES ##1 s_q.window == WINDOW_CYCLES - 12'h001)
        else $error("reference window wrong length");
    a_ready_steady: assert property (
        at_full && heads_loaded && s_q.delay_tmr == '0 && !skinc && !init |=> ready_indicator_out)
        else $error("ready not steady with heads loaded");
    a_init_loads: assert property (
        init |=> s_q.count == spindle_seq_pkg::SEQ_INIT && !s_q.drive_motor)
        else $error("power init did not load eight");
    a_retract_set: assert property (
        at_full && s_q.drive_motor && at_rate && seq_req && !emergency_retract && !s_q.safety && !init |=> s_q.retract_ok)
        else $error("retract flop not set at full count");
    a_speed_loss: assert property (
        !at_rate && s_q.retract_ok |=> !s_q.retract_ok)
        else $error("speed loss did not retract heads");
    a_safety_set: assert property (
        !at_rate && s_q.retract_ok && hd_ext && !init |=> s_q.safety)
        else $error("safety latch not set on indirect reset");
    a_safety_clear: assert property (
        s_q.safety && !hd_ext |=> !s_q.safety)
        else $error("safety latch kept with heads home");
    a_no_speed_slow: assert property (
        notch_fall && s_q.window == '0 && !at_rate |=> !at_rate_out)
        else $error("long notch pulse raised at rate");
    a_retrigger: assert property (
        s_qualify |=> s_q.at_rate_tmr == AT_RATE_CYCLES)
        else $error("long one-shot not retriggered");
    a_ready_flash: assert property (
        !term && !init |=> ready_indicator_out == $past(slow))
        else $error("ready not flashing with slow tick");
    a_ready_handover: assert property (
        at_full && !(heads_loaded && s_q.delay_tmr == '0 && !skinc) && !init |=> !ready_indicator_out)
        else $error("ready lit without heads loaded");
    a_ready_dark: assert property (
        at_zero |=> !ready_indicator_out)
        else $error("ready lit at empty count");
    a_delay_count: assert property (
        s_loaded |=> s_q.delay_tmr == $past(s_q.delay_tmr) - 20'h0_0001)
        else $error("heads loaded delay not counting");
    a_delay_load: assert property (
        !heads_loaded |=> s_q.delay_tmr == HEADS_LOADED_DELAY_CYCLES)
        else $error("heads loaded delay not held loaded");
    a_motor_start: assert property (
        at_zero && !s_q.brake && seq_req && !s_q.no_pack && !s_q.drive_motor && !init
        |=> s_q.drive_motor && s_q.count == 4'h1)
        else $error("request did not start motor");
    a_brake_blocks_start: assert property (
        s_q.brake && !s_q.drive_motor |=> !s_q.drive_motor)
        else $error("motor started while braking");
    a_brake_release: assert property (
        at_zero && !s_q.no_pack |=> !s_q.brake)
        else $error("brake held at empty count");
    a_no_pack_latch: assert property (
        s_pack_missing |=> s_motor_dropped)
        else $error("no-pack start not braked");
    a_init_clears: assert property (
        init |=> s_q.at_rate_tmr == '0 && s_q.window == '0 && !s_q.retract_ok)
        else $error("power init left timers running");
endmodule
`default_nettype wire

// ---- spindle_mechanics_model.sv ----
// behavioural spindle, notch sensor and head carriage model
`timescale 1ns/1ps
`default_nettype none
module spindle_mechanics_model (
    // clock and actuators seen from the drive
    input  wire logic clock_in,
    input  wire logic motor_power_relay_in,
    input  wire logic head_load_enable_n_in,
    input  wire logic fast_in,
    // sensed mechanics
    output logic      notch_sensor_out,
    output logic      heads_extended_out,
    output logic      heads_loaded_out
);
    int move_cnt = 0;
    int load_cnt = 0;
    int width;
    int period;
    initial begin
        notch_sensor_out   = 1'b0;
        heads_extended_out = 1'b0;
        heads_loaded_out   = 1'b0;
    end
    // slow spin: pulses longer than the window; fast spin: short random ones
    always begin
        @(posedge clock_in);
        #5;
        if (motor_power_relay_in === 1'b1) begin
            width            = (fast_in === 1'b1) ? 50 + int'($urandom % 300) : 3500;
            period           = (fast_in === 1'b1) ? 1000 : 4000;
            notch_sensor_out = 1'b1;
            repeat (width) @(posedge clock_in);
            #5;
            notch_sensor_out = 1'b0;
            repeat (period - width) @(posedge clock_in);
        end
    end
    // carriage needs 20 cycles to travel, tracks found 30 cycles after extending
    always @(posedge clock_in) begin
        #5;
        move_cnt = (heads_extended_out === head_load_enable_n_in) ? 0 : move_cnt + 1;
        if (move_cnt == 20) begin
            heads_extended_out = head_load_enable_n_in;
        end
        load_cnt         = (heads_extended_out === 1'b1) ? load_cnt + 1 : 0;
        heads_loaded_out = (load_cnt > 30);
    end
endmodule
`default_nettype wire

// ---- spindle_power_sequencer_tb.sv ----
// self-checking bench for the spindle power sequencer
`timescale 1ns/1ps
`default_nettype none
module spindle_power_sequencer_tb;
    typedef struct {string name; int idx; logic val;} note_s;
    localparam int MOT = 7, BRK = 6, HLE = 5, DRV = 4, TRM = 3, ATR = 2, HDD = 1, RDY = 0;
    logic       clock_in, arst_n_in, init_p, seq_st, panel_st, emerg, slow, skinc, fast;
    logic       notch, hext, hld, motor, brake, hle_n, drv, term, at_rate, hldd, ready;
    logic [7:0] obs;
    note_s      exp_q[$];
    note_s      n;
    int         bad_count = 0;
    int         checked = 0;
    int         cycles = 0;
    assign obs = {motor, brake, hle_n, drv, term, at_rate, hldd, ready};
    spindle_power_sequencer #(.AT_RATE_CYCLES(20'h0_07d0), .HEADS_LOADED_DELAY_CYCLES(20'h0_0032)) dut (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .power_init_pulse_in(init_p),
        .sequence_start_in(seq_st), .panel_start_latch_in(panel_st), .emergency_retract_in(emerg),
        .slow_sequence_tick_in(slow), .heads_extended_latch_in(hext), .notch_sensor_in(notch),
        .heads_loaded_in(hld), .seek_incomplete_in(skinc), .motor_power_relay_out(motor),
        .brake_out(brake), .head_load_enable_n_out(hle_n), .drive_motor_on_out(drv),
        .counter_terminal_flag_out(term), .at_rate_out(at_rate),
        .heads_loaded_delayed_out(hldd), .ready_indicator_out(ready));
    spindle_mechanics_model mech (.clock_in(clock_in), .motor_power_relay_in(motor),
        .head_load_enable_n_in(hle_n), .fast_in(fast), .notch_sensor_out(notch),
        .heads_extended_out(hext), .heads_loaded_out(hld));
    always #25 clock_in = ~clock_in;
    task automatic summarize();
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock_in);
        #5;
    endtask
    task automatic note(input string nm, input int idx, input logic val);
        exp_q.push_back('{nm, idx, val});
    endtask
    task automatic wait_for(input int idx, input logic val, input int max);
        for (int i = 0; i < max && obs[idx] !== val; i++) cyc(1);
    endtask
    // ready is sampled well inside each half so the 3-cycle sync lag never matters
    task automatic tick(input logic chk);
        slow = 1'b1;
        cyc(20);
        if (chk) note("ready", RDY, 1'b1);
        cyc(780);
        slow = 1'b0;
        cyc(20);
        if (chk) note("ready", RDY, 1'b0);
        cyc(780);
    endtask
    always @(negedge clock_in) begin
        while (exp_q.size() > 0) begin
            n = exp_q.pop_front();
            checked++;
            if (obs[n.idx] !== n.val) begin
                bad_count++;
                $display("[ERR] %s expected %b seen %b", n.name, n.val, obs[n.idx]);
            end
        end
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 90000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        {clock_in, arst_n_in, init_p, seq_st, panel_st, emerg, slow, skinc, fast} = 9'h000;
        void'($urandom(32'h0000_1aaf));
        cyc(5);
        arst_n_in = 1'b1;
        init_p = 1'b1;
        cyc(10);
        note("relay", MOT, 1'b0);
        init_p = 1'b0;
        cyc(10);
        note("brake", BRK, 1'b1);
        note("terminal", TRM, 1'b0);
        for (int i = 0; i < 8; i++) tick(i < 7);
        note("terminal", TRM, 1'b1);
        note("brake", BRK, 1'b0);
        note("ready", RDY, 1'b0);
        seq_st = 1'b1;
        wait_for(MOT, 1'b1, 20);
        note("relay", MOT, 1'b1);
        note("drive motor", DRV, 1'b1);
        cyc(2);
        note("terminal", TRM, 1'b0);
        for (int i = 0; i < 14; i++) begin
            if (i == 3) note("at rate", ATR, 1'b0);
            if (i == 3) fast = 1'b1;
            tick(i < 13);
        end
        note("terminal", TRM, 1'b1);
        note("at rate", ATR, 1'b1);
        wait_for(HLE, 1'b1, 20);
        note("head load enable", HLE, 1'b1);
        tick(1'b0);
        note("terminal", TRM, 1'b1);
        wait_for(HDD, 1'b1, 300);
        note("heads loaded delayed", HDD, 1'b1);
        cyc(2);
        note("ready", RDY, 1'b1);
        skinc = 1'b1;
        cyc(5);
        note("ready", RDY, 1'b0);
        skinc = 1'b0;
        emerg = 1'b1;
        cyc(5);
        note("head load enable", HLE, 1'b0);
        note("relay", MOT, 1'b1);
        emerg = 1'b0;
        cyc(100);
        // slow spin again: speed lost, heads retract while the pack keeps turning
        fast = 1'b0;
        wait_for(ATR, 1'b0, 4000);
        note("at rate", ATR, 1'b0);
        cyc(4);
        note("head load enable", HLE, 1'b0);
        note("relay", MOT, 1'b1);
        cyc(60);
        note("head load enable", HLE, 1'b0);
        fast = 1'b1;
        wait_for(HLE, 1'b1, 6000);
        note("head load enable", HLE, 1'b1);
        wait_for(HDD, 1'b1, 300);
        note("heads loaded delayed", HDD, 1'b1);
        seq_st = 1'b0;
        cyc(4);
        note("head load enable", HLE, 1'b0);
        wait_for(MOT, 1'b0, 300);
        note("relay", MOT, 1'b0);
        cyc(2);
        note("brake", BRK, 1'b1);
        note("terminal", TRM, 1'b0);
        for (int i = 0; i < 14; i++) tick(i < 13);
        note("terminal", TRM, 1'b1);
        note("ready", RDY, 1'b0);
        note("brake", BRK, 1'b0);
        cyc(2);
        // panel start with fast spin from the outset: no pack mounted
        panel_st = 1'b1;
        wait_for(MOT, 1'b1, 20);
        note("relay", MOT, 1'b1);
        tick(1'b1);
        note("at rate", ATR, 1'b1);
        tick(1'b1);
        note("relay", MOT, 1'b0);
        note("brake", BRK, 1'b1);
        panel_st = 1'b0;
        for (int i = 0; i < 3; i++) tick(i < 2);
        note("terminal", TRM, 1'b1);
        note("brake", BRK, 1'b0);
        cyc(2);
        summarize();
    end
endmodule
`default_nettype wire
